// >>> core/adc_threshold_comparators.sv
// Bank of four ADC threshold comparators with an APB register slave.
// Assumes ADC results arrive on pclk with a one-cycle valid strobe.
//
// Design decision made here: the APB slave port.
`include "adc_cmp_params.svh"
module adc_threshold_comparators (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [31:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire adc_cmp_pkg::adc_sample_t adc_sample,
  output logic      [3:0]               cmp_detected,
  output logic                          irq
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------

  adc_cmp_pkg::regs_state_t st_r, st_nxt;

  logic        setup;
  logic        access;
  logic        wr;
  logic [15:0] idx;
  logic        aligned;
  logic        mapped;
  logic [3:0]  hits;
  logic [3:0]  evts;
  logic [3:0]  irq_sts;
  logic [3:0]  irq_clr;
  logic [31:0] rd_mux;

  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign idx     = paddr[`IDX_MSB:`IDX_LSB];
  assign aligned = (paddr[31:`IDX_MSB+1] == '0) && (paddr[`IDX_LSB-1:0] == '0);

  always_comb begin
    case (idx)
      `IDX_CTL, `IDX_CMP1, `IDX_CMP2, `IDX_CMP3, `IDX_CMP4,
      `IDX_IRQ_STS, `IDX_IRQ_MSK: mapped = aligned;
      default:                    mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------

  always_comb begin
    rd_mux = '0;
    case (idx)
      `IDX_CTL: begin
        rd_mux[`CTL_EN_LSB +: 4]  = st_r.en;
        rd_mux[`CTL_STS_LSB +: 4] = hits;
      end
      `IDX_CMP1:    rd_mux[`CFG_MSB:0] = st_r.cfg[0];
      `IDX_CMP2:    rd_mux[`CFG_MSB:0] = st_r.cfg[1];
      `IDX_CMP3:    rd_mux[`CFG_MSB:0] = st_r.cfg[2];
      `IDX_CMP4:    rd_mux[`CFG_MSB:0] = st_r.cfg[3];
      `IDX_IRQ_STS: rd_mux[`IRQ_MSB:0] = irq_sts;
      `IDX_IRQ_MSK: rd_mux[`IRQ_MSB:0] = st_r.mask;
      default:      rd_mux = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------

  // Decode and read data are caught in the setup cycle, so the access
  // cycle answers at once from flip-flops with no wait state.
  assign wr = access && pwrite && !st_r.err;

  always_comb begin
    st_nxt  = st_r;
    irq_clr = '0;
    if (setup) begin
      st_nxt.err   = !mapped;
      st_nxt.rdata = (mapped && !pwrite) ? rd_mux : `RDATA_RESET;
    end
    if (wr) begin
      case (idx)
        `IDX_CTL:     st_nxt.en = pwdata[`CTL_EN_LSB +: 4];
        `IDX_CMP1:    st_nxt.cfg[0] = pwdata[`CFG_MSB:0];
        `IDX_CMP2:    st_nxt.cfg[1] = pwdata[`CFG_MSB:0];
        `IDX_CMP3:    st_nxt.cfg[2] = pwdata[`CFG_MSB:0];
        `IDX_CMP4:    st_nxt.cfg[3] = pwdata[`CFG_MSB:0];
        `IDX_IRQ_STS: irq_clr = pwdata[`IRQ_MSB:0];
        `IDX_IRQ_MSK: st_nxt.mask = pwdata[`IRQ_MSB:0];
        default:      st_nxt = st_nxt;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.en    <= `EN_RESET;
      st_r.mask  <= `MASK_RESET;
      st_r.cfg   <= {4{`CFG_RESET}};
      st_r.rdata <= `RDATA_RESET;
      st_r.err   <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pready  = access;
  assign pslverr = access && st_r.err;
  assign prdata  = st_r.rdata;

  // ----------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------

  cmp_unit #(
    .ZERO_CH (adc_cmp_pkg::CH_USB)
  ) u_cmp_one (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (st_r.en[0]),
    .cfg     (st_r.cfg[0]),
    .sample  (adc_sample),
    .hit     (hits[0]),
    .evt     (evts[0])
  );

  cmp_unit #(
    .ZERO_CH (adc_cmp_pkg::CH_WALL)
  ) u_cmp_two (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (st_r.en[1]),
    .cfg     (st_r.cfg[1]),
    .sample  (adc_sample),
    .hit     (hits[1]),
    .evt     (evts[1])
  );

  cmp_unit #(
    .ZERO_CH (adc_cmp_pkg::CH_BATT)
  ) u_cmp_three (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (st_r.en[2]),
    .cfg     (st_r.cfg[2]),
    .sample  (adc_sample),
    .hit     (hits[2]),
    .evt     (evts[2])
  );

  // Code zero stays reserved here; software that selects it gets silence.
  cmp_unit #(
    .ZERO_CH (adc_cmp_pkg::CH_NONE)
  ) u_cmp_four (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (st_r.en[3]),
    .cfg     (st_r.cfg[3]),
    .sample  (adc_sample),
    .hit     (hits[3]),
    .evt     (evts[3])
  );

  assign cmp_detected = hits;

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------

  irq_bank u_irq (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (evts),
    .clr     (irq_clr),
    .mask    (st_r.mask),
    .sts     (irq_sts),
    .irq     (irq)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  property p_cfg_write;
    @(posedge pclk) disable iff (!presetn)
    (wr && idx == `IDX_CMP2) |=> (st_r.cfg[1] == $past(pwdata[`CFG_MSB:0]));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config not stored");

  property p_isolated;
    @(posedge pclk) disable iff (!presetn)
    !(wr && idx == `IDX_CMP3) |=> $stable(st_r.cfg[2]);
  endproperty
  a_isolated: assert property (p_isolated) else $error("config changed");

  property p_status_read;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && idx == `IDX_CTL && aligned)
      |=> (prdata[`CTL_STS_LSB +: 4] == $past(hits));
  endproperty
  a_status_read: assert property (p_status_read) else $error("bad status");

  property p_answer;
    @(posedge pclk) disable iff (!presetn)
    (setup && !mapped) |=> (pslverr || !access);
  endproperty
  a_answer: assert property (p_answer) else $error("unmapped not flagged");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
    (evts[0] && st_r.mask[0]) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq missing");

  property p_en_write;
    @(posedge pclk) disable iff (!presetn)
    (wr && idx == `IDX_CTL) |=> (st_r.en == $past(pwdata[`CTL_EN_LSB +: 4]));
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable not stored");

  property p_mask_write;
    @(posedge pclk) disable iff (!presetn)
    (wr && idx == `IDX_IRQ_MSK) |=> (st_r.mask == $past(pwdata[`IRQ_MSB:0]));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not stored");

  property p_cfg_one;
    @(posedge pclk) disable iff (!presetn)
    (wr && idx == `IDX_CMP1) |=> (st_r.cfg[0] == $past(pwdata[`CFG_MSB:0]));
  endproperty
  a_cfg_one: assert property (p_cfg_one) else $error("config one not stored");

  property p_cfg_three;
    @(posedge pclk) disable iff (!presetn)
    (wr && idx == `IDX_CMP3) |=> (st_r.cfg[2] == $past(pwdata[`CFG_MSB:0]));
  endproperty
  a_cfg_three: assert property (p_cfg_three) else $error("config three not stored");

  property p_cfg_four;
    @(posedge pclk) disable iff (!presetn)
    (wr && idx == `IDX_CMP4) |=> (st_r.cfg[3] == $past(pwdata[`CFG_MSB:0]));
  endproperty
  a_cfg_four: assert property (p_cfg_four) else $error("config four not stored");

  property p_err_ignored;
    @(posedge pclk) disable iff (!presetn)
    (access && st_r.err)
      |=> ($stable(st_r.en) && $stable(st_r.mask) && $stable(st_r.cfg));
  endproperty
  a_err_ignored: assert property (p_err_ignored) else $error("refused write stored");

  property p_err_zero;
    @(posedge pclk) disable iff (!presetn)
    (setup && !mapped) |=> (prdata == `RDATA_RESET);
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused read not zero");

  property p_rdata_hold;
    @(posedge pclk) disable iff (!presetn)
    !setup |=> $stable(prdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_cfg_read;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && aligned && idx == `IDX_CMP4)
      |=> (prdata == {16'h0000, $past(st_r.cfg[3])});
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config read wrong");

  property p_mask_read;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && aligned && idx == `IDX_IRQ_MSK)
      |=> (prdata == {28'h000_0000, $past(st_r.mask)});
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask read wrong");

  property p_sts_read;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && aligned && idx == `IDX_IRQ_STS)
      |=> (prdata == {28'h000_0000, $past(irq_sts)});
  endproperty
  a_sts_read: assert property (p_sts_read) else $error("flag read wrong");

  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
    (irq_sts != '0)
      |=> ((irq_sts & $past(irq_sts & ~irq_clr)) == $past(irq_sts & ~irq_clr));
  endproperty
  a_sticky: assert property (p_sticky) else $error("event flag dropped");

  property p_no_spurious;
    @(posedge pclk) disable iff (!presetn)
    ((evts | irq_sts) == '0) |=> (irq_sts == '0);
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("flag set without event");

  property p_evt_enabled;
    @(posedge pclk) disable iff (!presetn)
    (evts != '0) |-> ((evts & $past(st_r.en)) == evts);
  endproperty
  a_evt_enabled: assert property (p_evt_enabled) else $error("event from disabled unit");

  property p_usb_zero;
    @(posedge pclk) disable iff (!presetn)
    (adc_sample.valid && st_r.en[0] && st_r.cfg[0].src == `SRC_CODE0 && !st_r.cfg[0].dir
      && adc_sample.chan == adc_cmp_pkg::CH_USB && adc_sample.data < st_r.cfg[0].thr)
      |=> evts[0];
  endproperty
  a_usb_zero: assert property (p_usb_zero) else $error("zero source one missed");

  property p_wall_zero;
    @(posedge pclk) disable iff (!presetn)
    (adc_sample.valid && st_r.en[1] && st_r.cfg[1].src == `SRC_CODE0 && !st_r.cfg[1].dir
      && adc_sample.chan == adc_cmp_pkg::CH_WALL && adc_sample.data < st_r.cfg[1].thr)
      |=> evts[1];
  endproperty
  a_wall_zero: assert property (p_wall_zero) else $error("zero source two missed");

  property p_batt_zero;
    @(posedge pclk) disable iff (!presetn)
    (adc_sample.valid && st_r.en[2] && st_r.cfg[2].src == `SRC_CODE0 && !st_r.cfg[2].dir
      && adc_sample.chan == adc_cmp_pkg::CH_BATT && adc_sample.data < st_r.cfg[2].thr)
      |=> evts[2];
  endproperty
  a_batt_zero: assert property (p_batt_zero) else $error("zero source three missed");

  c_write: cover property (@(posedge pclk) disable iff (!presetn) wr);
  c_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  c_all_hit: cover property (@(posedge pclk) disable iff (!presetn) &hits);
endmodule // adc_threshold_comparators

// >>> core/adc_cmp_params.svh
// Register indices, field positions and reset values of the comparator bank.
// Assumes an APB slave that turns each index into byte address index*4.
`ifndef ADC_CMP_PARAMS_SVH
`define ADC_CMP_PARAMS_SVH
`define IDX_CTL      16'h4030
`define IDX_CMP1     16'h4031
`define IDX_CMP2     16'h4032
`define IDX_CMP3     16'h4033
`define IDX_CMP4     16'h4034
`define IDX_IRQ_STS  16'h4035
`define IDX_IRQ_MSK  16'h4036
`define IDX_MSB      17
`define IDX_LSB      2
`define CTL_EN_LSB   0
`define CTL_STS_LSB  8
`define CFG_MSB      15
`define IRQ_MSB      3
`define CFG_RESET    16'h0000
`define EN_RESET     4'h0
`define MASK_RESET   4'h0
`define RDATA_RESET  32'h0000_0000
`define SRC_CODE0    3'h0
`endif

// >>> core/adc_cmp_pkg.sv
// Types shared by the comparator bank.
// Assumes the header of constants is compiled alongside.
package adc_cmp_pkg;
  typedef enum logic [3:0] {
    CH_EXT1 = 4'h0, CH_EXT2 = 4'h1, CH_EXT3 = 4'h2, CH_EXT4 = 4'h3,
    CH_DIE_TEMP = 4'h4, CH_BATT_TEMP = 4'h5, CH_SYS = 4'h6,
    CH_USB = 4'h7, CH_WALL = 4'h8, CH_BATT = 4'h9, CH_NONE = 4'hF
  } adc_chan_t;
  typedef struct packed {
    logic [2:0]  src;
    logic        dir;
    logic [11:0] thr;
  } cmp_cfg_t;
  typedef struct packed {
    logic        valid;
    adc_chan_t   chan;
    logic [11:0] data;
  } adc_sample_t;
  typedef struct packed {
    logic hit;
    logic evt;
  } cmp_state_t;
  typedef struct packed {
    logic [3:0] sts;
  } irq_state_t;
  typedef struct packed {
    logic [3:0]     en;
    logic [3:0]     mask;
    cmp_cfg_t [3:0] cfg;
    logic [31:0]    rdata;
    logic           err;
  } regs_state_t;
endpackage

// >>> core/cmp_unit.sv
// One threshold comparator: source match, direction and threshold test.
// Assumes ADC samples arrive on pclk as one-cycle valid strobes.
`include "adc_cmp_params.svh"
module cmp_unit #(
  parameter adc_cmp_pkg::adc_chan_t ZERO_CH = adc_cmp_pkg::CH_NONE
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     enable,
  input  wire adc_cmp_pkg::cmp_cfg_t    cfg,
  input  wire adc_cmp_pkg::adc_sample_t sample,
  output logic                          hit,
  output logic                          evt
);
  adc_cmp_pkg::cmp_state_t st_r, st_nxt;
  adc_cmp_pkg::adc_chan_t  sel_ch;
  logic                    match;
  logic                    cond;

  always_comb begin
    case (cfg.src)
      `SRC_CODE0: sel_ch = ZERO_CH;
      3'h1:       sel_ch = adc_cmp_pkg::CH_EXT1;
      3'h2:       sel_ch = adc_cmp_pkg::CH_EXT2;
      3'h3:       sel_ch = adc_cmp_pkg::CH_EXT3;
      3'h4:       sel_ch = adc_cmp_pkg::CH_EXT4;
      3'h5:       sel_ch = adc_cmp_pkg::CH_DIE_TEMP;
      3'h6:       sel_ch = adc_cmp_pkg::CH_BATT_TEMP;
      default:    sel_ch = adc_cmp_pkg::CH_SYS;
    endcase
    // A reserved source code maps to no channel and never matches.
    match = sample.valid && enable && (sample.chan == sel_ch)
            && (sel_ch != adc_cmp_pkg::CH_NONE);
    cond = cfg.dir ? (sample.data > cfg.thr)
                   : (sample.data < cfg.thr);
    st_nxt = st_r;
    st_nxt.evt = 1'b0;
    if (!enable) begin
      st_nxt.hit = 1'b0;
    end else if (match) begin
      st_nxt.hit = cond;
      st_nxt.evt = cond;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hit = st_r.hit;
  assign evt = st_r.evt;

  property p_below;
    @(posedge pclk) disable iff (!presetn)
    (match && !cfg.dir && sample.data < cfg.thr) |=> (hit && evt);
  endproperty
  a_below: assert property (p_below) else $error("below threshold missed");
  property p_above;
    @(posedge pclk) disable iff (!presetn)
    (match && cfg.dir && sample.data > cfg.thr) |=> (hit && evt);
  endproperty
  a_above: assert property (p_above) else $error("above threshold missed");
  property p_off;
    @(posedge pclk) disable iff (!presetn)
    !enable |=> (!hit && !evt);
  endproperty
  a_off: assert property (p_off) else $error("disabled comparator fired");
  property p_cause;
    @(posedge pclk) disable iff (!presetn)
    evt |-> $past(sample.valid && enable && sample.chan == sel_ch);
  endproperty
  a_cause: assert property (p_cause) else $error("event without sample");
  property p_reserved;
    @(posedge pclk) disable iff (!presetn)
    (cfg.src == `SRC_CODE0 && ZERO_CH == adc_cmp_pkg::CH_NONE) |=> !evt;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved source fired");
  c_fire: cover property (@(posedge pclk) disable iff (!presetn) evt);
endmodule // cmp_unit

// >>> core/irq_bank.sv
// Sticky event flags, write-one-to-clear, gated by a mask onto one level.
// Assumes set and clear strobes are one-cycle pulses on pclk.
`include "adc_cmp_params.svh"
module irq_bank (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [`IRQ_MSB:0]   set,
  input  wire logic [`IRQ_MSB:0]   clr,
  input  wire logic [`IRQ_MSB:0]   mask,
  output logic      [`IRQ_MSB:0]   sts,
  output logic                     irq
);
  adc_cmp_pkg::irq_state_t st_r, st_nxt;

  // A set arriving with its clear wins so no event is lost.
  always_comb begin
    st_nxt = st_r;
    st_nxt.sts = (st_r.sts & ~clr) | set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sts = st_r.sts;
  assign irq = |(st_r.sts & mask);

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
    (set != '0) |=> ((sts & $past(set)) == $past(set));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event flag lost");
  property p_clear;
    @(posedge pclk) disable iff (!presetn)
    (clr != '0 && set == '0) |=> ((sts & $past(clr)) == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule // irq_bank

// >>> sim/tb.sv
// Self-checking bench for the ADC threshold comparator bank.
// Assumes the package and the constant header are compiled before this file.
// It drives APB and ADC samples directly and compares every result with its own model.
`include "adc_cmp_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     pclk;
  logic                     presetn;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [31:0]              paddr;
  logic [31:0]              pwdata;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  adc_cmp_pkg::adc_sample_t adc_sample;
  logic [3:0]               cmp_detected;
  logic                     irq;
  int                       mismatches = 0;
  int                       n_tests = 0;
  logic [31:0]              seed = 32'h0000_3fb4;
  logic [31:0]              base = {14'h0000, `IDX_CTL, 2'b00};
  logic [3:0]               m_en, m_mask, m_sts, m_det;
  logic [15:0]              m_cfg [4];
  logic [31:0]              rd;
  logic                     er;

  adc_threshold_comparators adc_threshold_comparators_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_sample(adc_sample), .cmp_detected(cmp_detected), .irq(irq));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Channel that a comparator listens to for a given source code.
  function automatic logic [3:0] ch_of(input int i, input logic [2:0] s);
    if (s != 3'h0) return {1'b0, s} - 4'h1;
    case (i)
      0: return 4'h7;
      1: return 4'h8;
      2: return 4'h9;
      default: return 4'hf;
    endcase
  endfunction

  function automatic logic [31:0] exp_reg(input int k);
    case (k)
      0: return {20'h0_0000, m_det, 4'h0, m_en};
      5: return {28'h000_0000, m_sts};
      6: return {28'h000_0000, m_mask};
      default: return {16'h0000, m_cfg[k-1]};
    endcase
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // The master never assumes zero wait states; a wait past the cap ends the run.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk(32'h0000_0001, 32'h0000_0000);
      final_report();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input int k);
    apb(1'b0, base + 32'(4 * k), 32'h0000_0000, rd, er);
    chk(rd, exp_reg(k));
    chk({31'h0, er}, 32'h0000_0000);
  endtask

  task automatic wr(input int k, input logic [31:0] d);
    apb(1'b1, base + 32'(4 * k), d, rd, er);
    case (k)
      0: m_en = d[3:0];
      5: m_sts = m_sts & ~d[3:0];
      6: m_mask = d[3:0];
      default: m_cfg[k-1] = d[15:0];
    endcase
    m_det = m_det & m_en;
    @(posedge pclk);
    #1;
    chk({28'h000_0000, cmp_detected}, {28'h000_0000, m_det});
    chk({31'h0, irq}, {31'h0, |(m_sts & m_mask)});
  endtask

  task automatic sample(input logic [3:0] ch, input logic [11:0] dv);
    logic h;
    @(posedge pclk);
    adc_sample.valid <= 1'b1;
    adc_sample.chan  <= adc_cmp_pkg::adc_chan_t'(ch);
    adc_sample.data  <= dv;
    @(posedge pclk);
    adc_sample.valid <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (m_en[i] && ch == ch_of(i, m_cfg[i][15:13])) begin
        h = m_cfg[i][12] ? (dv > m_cfg[i][11:0]) : (dv < m_cfg[i][11:0]);
        m_det[i] = h;
        if (h) m_sts[i] = 1'b1;
      end
    end
    #1;
    chk({28'h000_0000, cmp_detected}, {28'h000_0000, m_det});
    // The flag register sits one stage behind the comparator, so irq follows a cycle later.
    @(posedge pclk);
    #1;
    chk({31'h0, irq}, {31'h0, |(m_sts & m_mask)});
  endtask

  // ----------------------------------------------------------------
  // Clock, reset, watchdog
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // The whole run takes under 2000 cycles, so this leaves a wide margin.
  initial begin
    repeat (40000) @(posedge pclk);
    mismatches++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    adc_sample = '0;
    m_en = 4'h0;
    m_mask = 4'h0;
    m_sts = 4'h0;
    m_det = 4'h0;
    for (int i = 0; i < 4; i++) m_cfg[i] = 16'h0000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 7; k++) rd_chk(k);
    apb(1'b0, base + 32'h0000_001c, 32'h0000_0000, rd, er);
    chk({31'h0, er}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    apb(1'b1, base + 32'h0000_0006, 32'hffff_ffff, rd, er);
    chk({31'h0, er}, 32'h0000_0001);
    $display("test 1 done: checks=%0d mismatches=%0d", n_tests, mismatches);
    for (int k = 1; k < 5; k++) wr(k, rnd());
    for (int k = 1; k < 5; k++) rd_chk(k);
    $display("test 2 done: checks=%0d mismatches=%0d", n_tests, mismatches);
    wr(6, 32'h0000_000f);
    for (int i = 0; i < 4; i++) begin
      wr(0, 32'(1 << i));
      for (int c = 0; c < 8; c++) begin
        wr(i + 1, {16'h0000, 3'(c), 1'(c), 12'h800});
        sample((i == 3 && c == 0) ? 4'(rnd() % 10) : ch_of(i, 3'(c)),
               12'h7ff + 12'(rnd() % 3));
        wr(5, 32'h0000_000f);
      end
    end
    $display("test 3 done: checks=%0d mismatches=%0d", n_tests, mismatches);
    for (int n = 0; n < 400; n++) begin
      case (rnd() % 8)
        0: wr(0, rnd());
        1: wr(1 + int'(rnd() % 4), rnd());
        2: wr(6, rnd());
        3: wr(5, rnd());
        4: rd_chk(int'(rnd() % 7));
        default: sample(4'(rnd() % 10), m_cfg[rnd() % 4][11:0] + 12'(rnd() % 3) - 12'h001);
      endcase
    end
    $display("test 4 done: checks=%0d mismatches=%0d", n_tests, mismatches);
    final_report();
  end
endmodule // tb
